// File: verilog/cxp_defines.svh
// Constants for the configuration space extension port
`ifndef CXP_DEFINES_SVH
`define CXP_DEFINES_SVH

// =====================================================================
// Widths
`define CXP_ADDR_W 10
`define CXP_PF_W 3
`define CXP_VF_W 11
`define CXP_DATA_W 32
`define CXP_BE_W 4

// =====================================================================
// Access codes
`define CXP_ACC_READ 4'h0
`define CXP_ACC_ALL 4'hf

// =====================================================================
// Timing: request-to-acknowledge latency in cycles
`define CXP_REQ_TO_ACK_LATENCY 8'h10
`define CXP_LAT_W 8

// =====================================================================
// Internal bridge register window (dword addresses held inside)
`define CXP_INT_LO 10'h000
`define CXP_INT_HI 10'h013

// =====================================================================
// User register file on the far end
`define CXP_USR_BASE 10'h014
`define CXP_USR_WORDS 8
`define CXP_USR_IDX_W 3
`define CXP_USR_RESET 32'h0000_0000

`endif

// File: verilog/cxp_pkg.sv
// Types for the configuration space extension port
`default_nettype none
`include "cxp_defines.svh"

package cxp_pkg;
    typedef logic [`CXP_ADDR_W-1:0] cxp_addr_t;
    typedef logic [`CXP_DATA_W-1:0] cxp_data_t;
    typedef logic [`CXP_BE_W-1:0] cxp_be_t;
    typedef enum logic [1:0] {
        CXP_IDLE = 2'b00,
        CXP_WAIT = 2'b01,
        CXP_CPL = 2'b10
    } cxp_state_e;
endpackage

`default_nettype wire

// File: verilog/cxp_if.sv
// Interface joining the bridge end and the user register end
`default_nettype none
`include "cxp_defines.svh"

interface cxp_if;
    logic ext_req;
    logic ext_ack;
    logic [`CXP_ADDR_W-1:0] ext_addr;
    logic [`CXP_PF_W-1:0] ext_phys_function_number;
    logic [`CXP_VF_W-1:0] ext_virt_function_number;
    logic ext_virt_function_active;
    logic [`CXP_DATA_W-1:0] ext_rdata;
    logic [`CXP_DATA_W-1:0] ext_wdata;
    logic [`CXP_BE_W-1:0] ext_acc;

    modport bridge (
        output ext_req, ext_addr, ext_phys_function_number,
        output ext_virt_function_number, ext_virt_function_active,
        output ext_wdata, ext_acc,
        input ext_ack, ext_rdata
    );
    modport user (
        input ext_req, ext_addr, ext_phys_function_number,
        input ext_virt_function_number, ext_virt_function_active,
        input ext_wdata, ext_acc,
        output ext_ack, ext_rdata
    );
endinterface

`default_nettype wire

// File: verilog/cxp_bridge.sv
// Bridge end: forwards unmatched config accesses and builds completions
// How it works
// - Forward requests missing internal registers
// - User acks only supported registers
// - Reads need ack and data; writes ack
// - Ack yields completion; writes carry no data
// - No ack in time: zero completion
// - Hold address, function, data until ack
// - User acks within configured latency
// - Request high while valid; drop at ack
// - Ack high exactly one cycle
// - Ten-bit dword address
// - Three-bit physical function number
// - Eleven-bit virtual function number
// - VF active high for VF, low PF
// - Read data valid with ack
// - Write data on output bus
// - Code bit n enables byte n
// - User updates only enabled bytes
// - Shared register space across functions
`default_nettype none
`include "cxp_defines.svh"

module cxp_bridge
    import cxp_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Incoming configuration access from the bridge core
    input wire logic cfg_valid_i,
    input wire logic [`CXP_ADDR_W-1:0] cfg_addr_i,
    input wire logic [`CXP_PF_W-1:0] cfg_pf_i,
    input wire logic [`CXP_VF_W-1:0] cfg_vf_i,
    input wire logic cfg_vf_active_i,
    input wire logic [`CXP_BE_W-1:0] cfg_acc_i,
    input wire logic [`CXP_DATA_W-1:0] cfg_wdata_i,
    output logic cfg_ready_o,
    // Completion toward the requester
    output logic cpl_valid_o,
    output logic cpl_has_data_o,
    output logic [`CXP_DATA_W-1:0] cpl_data_o,
    output logic [2:0] cpl_status_o,
    output logic cpl_timeout_o,
    // Extension port
    cxp_if.bridge ext
);

    // =================================================================
    // Decode
    // Offset form of the range test: a window starting at zero gives no constant compare
    function automatic logic is_internal(input logic [`CXP_ADDR_W-1:0] a);
        logic [`CXP_ADDR_W-1:0] rel;
        rel = a - `CXP_INT_LO;
        is_internal = (rel <= (`CXP_INT_HI - `CXP_INT_LO));
    endfunction

    // An all-zero access code reads; any set bit makes a byte-enabled write
    function automatic logic is_read(input logic [`CXP_BE_W-1:0] code);
        is_read = (code == `CXP_ACC_READ);
    endfunction

    cxp_state_e state_r;
    logic [`CXP_LAT_W-1:0] wait_cnt_r;
    logic req_r;
    logic [`CXP_ADDR_W-1:0] addr_r;
    logic [`CXP_PF_W-1:0] pf_r;
    logic [`CXP_VF_W-1:0] vf_r;
    logic vf_act_r;
    logic [`CXP_BE_W-1:0] acc_r;
    logic [`CXP_DATA_W-1:0] wdata_r;
    logic take;
    logic timeout;
    logic acked;

    // Internal hits are answered by the bridge core, never seen here
    assign take = (state_r == CXP_IDLE) && cfg_valid_i && !is_internal(cfg_addr_i);
    // An ack outside WAIT answers no request and is ignored
    assign acked = (state_r == CXP_WAIT) && ext.ext_ack;
    // Excluding the ack lets a last-cycle ack win over the timeout
    assign timeout = (state_r == CXP_WAIT) && !ext.ext_ack
                     && (wait_cnt_r == `CXP_REQ_TO_ACK_LATENCY);

    // =================================================================
    // Sequencer
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r <= CXP_IDLE;
        end else begin
            unique case (state_r)
                CXP_IDLE: begin
                    if (take) begin
                        state_r <= CXP_WAIT;
                    end
                end
                CXP_WAIT: begin
                    if (acked || timeout) begin
                        state_r <= CXP_CPL;
                    end
                end
                // One cycle back to idle keeps requests from overlapping
                CXP_CPL: begin
                    state_r <= CXP_IDLE;
                end
                default: begin
                    state_r <= CXP_IDLE;
                end
            endcase
        end
    end

    // =================================================================
    // Acknowledge timeout
    // Counts WAIT cycles from one, so the limit equals the allowed latency
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wait_cnt_r <= '0;
        end else if (state_r == CXP_WAIT) begin
            wait_cnt_r <= wait_cnt_r + `CXP_LAT_W'(1);
        end else begin
            wait_cnt_r <= `CXP_LAT_W'(1);
        end
    end

    // =================================================================
    // Request and held fields
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            req_r <= 1'b0;
        end else if (take) begin
            req_r <= 1'b1;
        end else if (acked || timeout) begin
            req_r <= 1'b0;
        end
    end

    // Fields load only on take, so they stay put until the ack
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            addr_r <= '0;
            pf_r <= '0;
            vf_r <= '0;
            vf_act_r <= 1'b0;
            acc_r <= `CXP_ACC_READ;
            wdata_r <= '0;
        end else if (take) begin
            addr_r <= cfg_addr_i;
            pf_r <= cfg_pf_i;
            vf_r <= cfg_vf_i;
            vf_act_r <= cfg_vf_active_i;
            acc_r <= cfg_acc_i;
            wdata_r <= cfg_wdata_i;
        end
    end

    // =================================================================
    // Extension port outputs
    // All driven from registers so the user end never sees a decode glitch
    assign ext.ext_req = req_r;
    assign ext.ext_addr = addr_r;
    assign ext.ext_phys_function_number = pf_r;
    assign ext.ext_virt_function_number = vf_r;
    assign ext.ext_virt_function_active = vf_act_r;
    assign ext.ext_acc = acc_r;
    assign ext.ext_wdata = wdata_r;

    // =================================================================
    // Accept and completion
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cfg_ready_o <= 1'b0;
        end else begin
            // Lags the take by one cycle; the source holds valid until it sees this
            cfg_ready_o <= take;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cpl_valid_o <= 1'b0;
            cpl_has_data_o <= 1'b0;
            cpl_data_o <= '0;
            cpl_status_o <= 3'h0;
            cpl_timeout_o <= 1'b0;
        end else begin
            cpl_valid_o <= 1'b0;
            cpl_timeout_o <= 1'b0;
            if (acked) begin
                cpl_valid_o <= 1'b1;
                cpl_has_data_o <= is_read(acc_r);
                cpl_data_o <= is_read(acc_r) ? ext.ext_rdata : '0;
                cpl_status_o <= 3'h0;
            end else if (timeout) begin
                cpl_valid_o <= 1'b1;
                cpl_timeout_o <= 1'b1;
                // A timed-out read still reports a read completion, of zero data
                cpl_has_data_o <= is_read(acc_r);
                cpl_data_o <= '0;
                cpl_status_o <= 3'h0;
            end
        end
    end

endmodule

`default_nettype wire

// File: verilog/cxp_user_regs.sv
// User end: small register file answering extension port requests
`default_nettype none
`include "cxp_defines.svh"

module cxp_user_regs
    import cxp_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // Extension port
    cxp_if.user ext,
    // User-side view
    output logic wr_strobe_o,
    output logic [`CXP_DATA_W-1:0] reg0_o
);

    logic [`CXP_DATA_W-1:0] mem_r [`CXP_USR_WORDS];
    logic ack_r;
    logic done_r;
    logic [`CXP_DATA_W-1:0] rdata_r;
    logic [`CXP_ADDR_W-1:0] offs;
    logic hit;
    logic [`CXP_USR_IDX_W-1:0] idx;
    logic fresh;

    // One register set serves every function, so the function numbers go unread
    assign offs = ext.ext_addr - `CXP_USR_BASE;
    assign hit = (ext.ext_addr >= `CXP_USR_BASE)
                 && (offs < `CXP_ADDR_W'(`CXP_USR_WORDS));
    assign idx = offs[`CXP_USR_IDX_W-1:0];
    // First cycle of a mapped request: the only cycle that acks and writes
    assign fresh = ext.ext_req && hit && !done_r && !ack_r;

    // Ack once per request while it is up; unmapped addresses are left to time out
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ack_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            ack_r <= fresh;
            if (!ext.ext_req) begin
                done_r <= 1'b0;
            end else if (ack_r) begin
                done_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_r <= '0;
        end else if (ext.ext_req && hit) begin
            rdata_r <= mem_r[idx];
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < `CXP_USR_WORDS; i++) begin
                mem_r[i] <= `CXP_USR_RESET;
            end
        end else if (fresh) begin
            for (int b = 0; b < `CXP_BE_W; b++) begin
                if (ext.ext_acc[b]) begin
                    mem_r[idx][8*b +: 8] <= ext.ext_wdata[8*b +: 8];
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_strobe_o <= 1'b0;
            reg0_o <= '0;
        end else begin
            wr_strobe_o <= fresh && (ext.ext_acc != `CXP_ACC_READ);
            reg0_o <= mem_r[0];
        end
    end

    assign ext.ext_ack = ack_r;
    assign ext.ext_rdata = rdata_r;

endmodule

`default_nettype wire

// File: verification/cxp_props.sv
// Assertions on the extension port between the two ends
`default_nettype none
`include "cxp_defines.svh"

module cxp_props (
    // Port signals
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic ext_req,
    input wire logic ext_ack,
    input wire logic [`CXP_ADDR_W-1:0] ext_addr,
    input wire logic [`CXP_PF_W-1:0] ext_phys_function_number,
    input wire logic [`CXP_VF_W-1:0] ext_virt_function_number,
    input wire logic ext_virt_function_active,
    input wire logic [`CXP_DATA_W-1:0] ext_wdata,
    input wire logic [`CXP_BE_W-1:0] ext_acc
);
    // ==================================================
    // Checks
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    wire hit = ext_addr >= `CXP_USR_BASE && ext_addr < `CXP_USR_BASE + `CXP_USR_WORDS;
    sequence s_ack_drop;
        ext_ack ##1 !ext_req;
    endsequence
    int_miss_a: assert property (ext_req |-> ext_addr > `CXP_INT_HI)
        else $error("request for internal address");
    user_ack_a: assert property ($rose(ext_req) && hit |-> ##1 s_ack_drop)
        else $error("user register not acked");
    miss_ack_a: assert property (ext_req && !hit |-> !ext_ack)
        else $error("ack for unmapped address");
    ack_bound_a: assert property ($rose(ext_req) |-> ##[1:17] !ext_req)
        else $error("request outlives latency bound");
    field_hold_a: assert property (ext_req ##1 ext_req |-> $stable({ext_addr, ext_acc,
        ext_phys_function_number, ext_virt_function_number, ext_virt_function_active,
        ext_wdata}))
        else $error("fields moved during request");
    ack_pulse_a: assert property (ext_ack |=> !ext_ack)
        else $error("ack longer than one cycle");
    ack_in_req_a: assert property (ext_ack |-> ext_req)
        else $error("ack without request");
    req_drop_a: assert property (ext_ack |=> !ext_req)
        else $error("request held after ack");
endmodule

`default_nettype wire

// File: verification/tb_config_space_extension_port.sv
// Testbench joining bridge and user end through the extension port
`default_nettype none
`include "cxp_defines.svh"

module tb_config_space_extension_port import cxp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic cfg_valid_i = 1'b0;
    cxp_addr_t cfg_addr_i = '0;
    logic [2:0] cfg_pf_i = '0;
    logic [10:0] cfg_vf_i = '0;
    logic cfg_vf_active_i = 1'b0;
    cxp_be_t cfg_acc_i = '0;
    cxp_data_t cfg_wdata_i = '0;
    logic cfg_ready_o, cpl_valid_o, cpl_has_data_o, cpl_timeout_o, wr_strobe_o;
    cxp_data_t cpl_data_o, reg0_o;
    logic [2:0] cpl_status_o;
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;
    cxp_if i_cxp_if();
    cxp_bridge i_cxp_bridge(.sys_clk_i, .rstn_i, .cfg_valid_i, .cfg_addr_i, .cfg_pf_i,
        .cfg_vf_i, .cfg_vf_active_i, .cfg_acc_i, .cfg_wdata_i, .cfg_ready_o, .cpl_valid_o,
        .cpl_has_data_o, .cpl_data_o, .cpl_status_o, .cpl_timeout_o, .ext(i_cxp_if));
    cxp_user_regs i_cxp_user_regs(.sys_clk_i, .rstn_i, .ext(i_cxp_if), .wr_strobe_o, .reg0_o);
    cxp_props i_cxp_props(.sys_clk_i, .rstn_i, .ext_req(i_cxp_if.ext_req),
        .ext_ack(i_cxp_if.ext_ack), .ext_addr(i_cxp_if.ext_addr), .ext_acc(i_cxp_if.ext_acc),
        .ext_phys_function_number(i_cxp_if.ext_phys_function_number),
        .ext_virt_function_number(i_cxp_if.ext_virt_function_number),
        .ext_virt_function_active(i_cxp_if.ext_virt_function_active),
        .ext_wdata(i_cxp_if.ext_wdata));

    // ==================================================
    // Clock and hang guard
    initial begin
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    // Whole run is under 150 cycles; twenty times that means a hang
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_count++;
            summarize();
        end
    end

    // ==================================================
    // Tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask
    task automatic step();
        @(posedge sys_clk_i);
        #1;
    endtask
    // Function fields derive from the address so both vf_active levels occur
    task automatic xfer(input cxp_addr_t a, input cxp_be_t be, input cxp_data_t wd,
        input cxp_data_t exp_d, input logic to);
        int n;
        logic ws;
        cfg_addr_i = a;
        cfg_acc_i = be;
        cfg_wdata_i = wd;
        cfg_pf_i = a[2:0];
        cfg_vf_i = {a, 1'b1};
        cfg_vf_active_i = a[0];
        cfg_valid_i = 1'b1;
        n = 0;
        do begin
            step();
            n++;
        end while (cfg_ready_o !== 1'b1 && n < 40);
        chk("ready", 1, cfg_ready_o);
        chk("ext_req", 1, i_cxp_if.ext_req);
        chk("ext_addr", a, i_cxp_if.ext_addr);
        chk("pf", cfg_pf_i, i_cxp_if.ext_phys_function_number);
        chk("vf", cfg_vf_i, i_cxp_if.ext_virt_function_number);
        chk("vf_active", cfg_vf_active_i, i_cxp_if.ext_virt_function_active);
        chk("wdata", wd, i_cxp_if.ext_wdata);
        chk("acc", be, i_cxp_if.ext_acc);
        step();
        // The write strobe pulses with the ack, a cycle before the completion
        ws = wr_strobe_o;
        cfg_valid_i = 1'b0;
        n = 0;
        while (cpl_valid_o !== 1'b1 && n < 40) begin
            step();
            ws = ws | wr_strobe_o;
            n++;
        end
        chk("cpl_valid", 1, cpl_valid_o);
        chk("cpl_timeout", to, cpl_timeout_o);
        chk("cpl_status", 0, cpl_status_o);
        chk("has_data", be == 4'h0, cpl_has_data_o);
        chk("cpl_data", exp_d, cpl_data_o);
        chk("wr_strobe", be != 4'h0 && !to, ws);
    endtask
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ==================================================
    // Tests
    initial begin
        repeat (10) step();
        rstn_i = 1'b1;
        xfer(10'h014, 4'hf, 32'h1111_1234, 0, 0);
        step();
        chk("reg0", 32'h1111_1234, reg0_o);
        xfer(10'h014, 4'hc, 32'h5621_aaaa, 0, 0);
        xfer(10'h014, 4'h0, 0, 32'h5621_1234, 0);
        $display("test merge done");
        for (int i = 0; i < 4; i++) begin
            xfer(10'h015, cxp_be_t'(1 << i), 32'hffff_ffff, 0, 0);
            xfer(10'h015, 4'h0, 0, 32'hffff_ffff >> (24 - 8 * i), 0);
        end
        xfer(10'h01b, 4'h5, 32'ha5a5_a5a5, 0, 0);
        xfer(10'h01b, 4'h0, 0, 32'h00a5_00a5, 0);
        $display("test lanes done");
        xfer(10'h01c, 4'h0, 0, 0, 1);
        xfer(10'h3ff, 4'h3, 32'hdead_beef, 0, 1);
        $display("test timeout done");
        // Highest internal address must never reach the port
        cfg_addr_i = 10'h013;
        cfg_valid_i = 1'b1;
        repeat (30) begin
            step();
            chk("ready", 0, cfg_ready_o);
            chk("ext_req", 0, i_cxp_if.ext_req);
        end
        cfg_valid_i = 1'b0;
        $display("test internal done");
        summarize();
    end
endmodule

`default_nettype wire
